// ===== bench/panel_output_timing_control_tb.sv
module panel_output_timing_control_tb
  import panel_timing_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // Base configurations; bit 25 is always written as one.
  localparam logic [31:0] CFG_TFT = 32'h0710_0000;
  localparam logic [31:0] CFG_STN = 32'h0200_0000;

  logic                   hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0]            haddr, hwdata, hrdata, rd;
  logic [1:0]             htrans;
  logic [2:0]             hsize;
  logic                   pclk, in_hs, in_vs, in_de;
  logic [PIXEL_WIDTH-1:0] in_pix, panel_data;
  logic                   mclk_strobe, shift_clk, strobe, line_pin, frame_pin, cap_ready;
  logic                   prev_shift;
  int                     n_fail, cmp_count, n_strobe, n_shift;
  logic [31:0]            cfg;

  // Free-running bus clock at 250 MHz.
  initial hclk = 1'b0;
  always #2 hclk = ~hclk;

  pixel_source src_u (
    .pixel_clock (pclk),
    .hsync       (in_hs),
    .vsync       (in_vs),
    .data_enable (in_de),
    .pixel       (in_pix)
  );

  panel_output_timing_control dut_u (
    .hclk                     (hclk),
    .hresetn                  (hresetn),
    .hsel                     (hsel),
    .haddr                    (haddr),
    .htrans                   (htrans),
    .hwrite                   (hwrite),
    .hsize                    (hsize),
    .hwdata                   (hwdata),
    .hready                   (hreadyout),
    .hrdata                   (hrdata),
    .hreadyout                (hreadyout),
    .hresp                    (hresp),
    .pixel_clock              (pclk),
    .incoming_horizontal_sync (in_hs),
    .incoming_vertical_sync   (in_vs),
    .incoming_data_enable     (in_de),
    .incoming_pixel           (in_pix),
    .memory_clock_strobe      (mclk_strobe),
    .panel_shift_clock        (shift_clk),
    .display_data_strobe      (strobe),
    .line_pin_out             (line_pin),
    .frame_pin_out            (frame_pin),
    .panel_data               (panel_data),
    .capture_ready            (cap_ready)
  );

  // Counts memory clock ticks and shift clock rises for the rate checks.
  always @(posedge hclk)
  begin
    prev_shift <= shift_clk;
    if (mclk_strobe === 1'b1) n_strobe++;
    if (shift_clk === 1'b1 && prev_shift === 1'b0) n_shift++;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One single-word transfer; the address phase is held until hready is seen high.
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= w;
    hsize  <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask

  // Streams samples, then lets the synchroniser and buffer settle.
  task automatic px(input int n, input logic h, input logic v, input logic e,
                    input logic [PIXEL_WIDTH-1:0] p);
    src_u.frame(n, h, v, e, p);
    repeat (12) @(posedge hclk);
  endtask

  task automatic done(input string name);
    $display("test %s finished, mismatches so far %0d", name, n_fail);
  endtask

  task automatic summarize;
    $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Watchdog sized well beyond the expected run of about 14 us.
  initial
  begin
    #200000;
    n_fail++;
    summarize();
  end

  initial
  begin
    n_fail = 0; cmp_count = 0; n_strobe = 0; n_shift = 0;
    hresetn = 1'b0; hsel = 1'b0; haddr = '0; htrans = 2'b00;
    hwrite = 1'b0; hsize = 3'h2; hwdata = '0; prev_shift = 1'b0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk(32'(strobe), 32'h1);
    chk(32'(hresp), 32'h0);
    rdc(32'h404, 32'h0000_0000);
    rdc(32'h400, 32'h0000_0000);
    done("reset");

    // Register access, reserved bit and an unmapped address.
    wr(32'h404, 32'hffff_ffff);
    rdc(32'h404, 32'hefff_ffff);
    wr(32'h40c, 32'h1234_5678);
    rdc(32'h40c, 32'h0000_0000);
    wr(32'h400, 32'h4000_0000);
    rdc(32'h400, 32'h4000_0000);
    wr(32'h400, 32'h0000_0000);
    done("registers");

    // Strobe, line and frame polarities for both panel types.
    for (int k = 0; k < 16; k++)
    begin
      cfg = (k[3] ? CFG_TFT : CFG_STN) | (32'(k[0]) << 29) | (32'(k[1]) << 23)
            | (32'(k[2]) << 22);
      wr(32'h404, cfg);
      px(2, 1'b0, 1'b1, 1'b1, 18'h0abcd);
      chk(32'(strobe), 32'(k[0]));
      chk(32'(line_pin), 32'(k[2] & k[3]));
      chk(32'(frame_pin), 32'(1'b1 ^ (k[1] & k[3])));
      chk(32'(panel_data), 32'h0abcd);
    end
    done("polarity");

    // Monochrome copies green to every channel.
    wr(32'h404, CFG_STN | 32'h0008_0000);
    px(2, 1'b0, 1'b0, 1'b1, {6'h11, 6'h22, 6'h33});
    chk(32'(panel_data), 32'({6'h22, 6'h22, 6'h22}));
    done("mono");

    // Input vertical polarity comes from the first register only.
    wr(32'h400, 32'h4000_0000);
    wr(32'h404, CFG_STN);
    px(2, 1'b0, 1'b1, 1'b1, 18'h00001);
    chk(32'(frame_pin), 32'h0);
    done("input polarity");

    // Line pulse starts at the input edge and ends at a two-pixel trailing position.
    wr(32'h400, 32'h0000_0002);
    px(2, 1'b0, 1'b0, 1'b1, 18'h00007);
    px(2, 1'b1, 1'b0, 1'b1, 18'h00007);
    chk(32'(line_pin), 32'h1);
    px(2, 1'b1, 1'b0, 1'b1, 18'h00007);
    chk(32'(line_pin), 32'h0);
    done("line pulse");

    // Bypass ignores timing fields, polarities and mono handling.
    wr(32'h400, 32'h4000_00ff);
    wr(32'h404, CFG_TFT | 32'h60c8_0000);
    px(2, 1'b1, 1'b1, 1'b0, {6'h11, 6'h22, 6'h33});
    chk(32'(strobe), 32'h0);
    chk(32'(line_pin), 32'h1);
    chk(32'(frame_pin), 32'h1);
    chk(32'(panel_data), 32'({6'h11, 6'h22, 6'h33}));
    wr(32'h400, 32'h0000_0000);
    done("bypass");

    // Shift clock gated outside active display unless TFT retrace activity is on.
    wr(32'h404, CFG_STN);
    n_shift = 0;
    px(8, 1'b0, 1'b0, 1'b0, 18'h00002);
    chk(32'(n_shift), 32'd0);
    wr(32'h404, CFG_TFT | 32'h0800_0000);
    n_shift = 0;
    px(8, 1'b0, 1'b0, 1'b0, 18'h00003);
    chk(32'(n_shift), 32'd8);
    done("shift clock");

    // Memory clock ticks at full and two-thirds rate.
    wr(32'h404, CFG_STN);
    n_strobe = 0;
    px(6, 1'b0, 1'b0, 1'b1, 18'h00004);
    chk(32'(n_strobe), 32'd6);
    wr(32'h404, CFG_STN | 32'h8000_0000);
    n_strobe = 0;
    px(6, 1'b0, 1'b0, 1'b1, 18'h00005);
    chk(32'(n_strobe), 32'd4);
    done("ratio");

    // At two-thirds rate a continuous stream fills the buffer until it refuses.
    px(120, 1'b0, 1'b0, 1'b1, 18'h00006);
    chk(32'(cap_ready), 32'h0);
    rdc(32'h408, 32'h0000_2001);
    wr(32'h408, 32'h0000_0001);
    rdc(32'h408, 32'h0000_2000);
    done("overflow");
    summarize();
  end
endmodule

// ===== bench/pixel_source.sv
module pixel_source
  import panel_timing_pkg::*;
(
  // Link clock.
  output logic                   pixel_clock,
  // Link timing levels.
  output logic                   hsync,
  output logic                   vsync,
  output logic                   data_enable,
  // Link pixel word.
  output logic [PIXEL_WIDTH-1:0] pixel
);
  timeunit 1ns;
  timeprecision 100ps;

  // The link clock stands low between frames, as a real source would.
  initial
  begin
    pixel_clock = 1'b0;
    hsync       = 1'b0;
    vsync       = 1'b0;
    data_enable = 1'b0;
    pixel       = '0;
  end

  // Sends n identical samples at a 64 ns pixel period.
  // Data change only while the clock is low, so they are stable around each rise.
  // Every change lands on a bus clock edge, so it is scheduled after that edge samples.
  task automatic frame(input int n, input logic h, input logic v, input logic e,
                       input logic [PIXEL_WIDTH-1:0] p);
    hsync       <= h;
    vsync       <= v;
    data_enable <= e;
    pixel       <= p;
    for (int i = 0; i < n; i++)
    begin
      #32 pixel_clock <= 1'b1;
      #32 pixel_clock <= 1'b0;
    end
  endtask
endmodule

// ===== hw/panel_output_timing_control.sv
module panel_output_timing_control
  import panel_timing_pkg::*;
#(
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEFAULT
)
(
  // Bus clock and reset.
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  // AHB-Lite slave.
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic [31:0]                 hrdata,
  output logic                        hreadyout,
  output logic                        hresp,
  // Incoming pixel stream.
  input  wire logic                   pixel_clock,
  input  wire logic                   incoming_horizontal_sync,
  input  wire logic                   incoming_vertical_sync,
  input  wire logic                   incoming_data_enable,
  input  wire logic [PIXEL_WIDTH-1:0] incoming_pixel,
  // Panel side.
  output logic                        memory_clock_strobe,
  output logic                        panel_shift_clock,
  output logic                        display_data_strobe,
  output logic                        line_pin_out,
  output logic                        frame_pin_out,
  output logic [PIXEL_WIDTH-1:0]      panel_data,
  output logic                        capture_ready
);

  localparam int LW = $clog2(FIFO_DEPTH) + 1;

  logic [SAMPLE_WIDTH:0]   link_meta;
  logic [SAMPLE_WIDTH:0]   link_sync;
  logic                    pixel_clock_prev;
  logic                    pix_level;
  logic                    pix_rise;
  logic [31:0]             timing_first;
  logic [31:0]             timing_second;
  logic                    overflow;
  logic [1:0]              ratio_count;
  logic                    fill_ready;
  logic                    drain_valid;
  logic [SAMPLE_WIDTH-1:0] drain_data;
  logic [LW-1:0]           fifo_level;
  logic                    pop;
  logic                    w_de;
  logic                    w_hs;
  logic                    w_vs;
  logic [PIXEL_WIDTH-1:0]  w_pix;
  logic [CHAN_W-1:0]       w_green;
  logic                    vs_mod;
  logic                    hs_prev;
  logic                    hs_edge;
  logic [5:0]              hs_pos;
  logic [5:0]              next_pos;
  logic [5:0]              lead_pos;
  logic                    gen_h;
  logic                    out_de;
  logic                    shift_gate;
  bus_state_t              bus_state;
  logic [11:0]             bus_addr;
  logic                    wr_pending;
  logic                    addr_phase;
  logic [31:0]             read_word;
  logic                    status_clear;
  logic                    mem_ratio;
  logic                    bypass;
  logic                    strobe_pol;
  logic                    retrace;
  logic                    line_sel;
  logic                    frame_sel;
  logic                    vertical_sync_out_polarity;
  logic                    horizontal_sync_out_polarity;
  logic                    is_tft;
  logic                    mono;
  logic                    in_vertical_sync_out_polarity;
  logic [2:0]              lead_sel;
  logic [4:0]              trail;

  default clocking dc @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // Control fields decoded from the two timing registers.
  assign mem_ratio    = timing_second[BIT_MEM_RATIO];
  assign bypass       = timing_second[BIT_BYPASS];
  assign strobe_pol   = timing_second[BIT_STROBE_POL];
  assign retrace      = timing_second[BIT_SHIFT_RETRACE];
  assign line_sel     = timing_second[BIT_LINE_SEL];
  assign frame_sel    = timing_second[BIT_FRAME_SEL];
  assign vertical_sync_out_polarity    = timing_second[BIT_VERTICAL_SYNC_OUT_POLARITY];
  assign horizontal_sync_out_polarity    = timing_second[BIT_HORIZONTAL_SYNC_OUT_POLARITY];
  assign is_tft       = (timing_second[TYPE_HI:TYPE_LO] == PANEL_TFT);
  assign mono         = timing_second[BIT_MONO];
  assign in_vertical_sync_out_polarity = timing_first[BIT_IN_VERTICAL_SYNC_OUT_POLARITY];
  assign lead_sel     = timing_first[LEAD_HI:LEAD_LO];
  assign trail        = timing_first[TRAIL_HI:TRAIL_LO];

  // Every link pin passes two flops; edges are found only on the second stage.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      link_meta        <= '0;
      link_sync        <= '0;
      pixel_clock_prev <= 1'b0;
    end
    else
    begin
      link_meta        <= {pixel_clock, incoming_data_enable, incoming_horizontal_sync,
                           incoming_vertical_sync, incoming_pixel};
      link_sync        <= link_meta;
      pixel_clock_prev <= link_sync[SAMPLE_WIDTH];
    end
  end

  assign pix_level = link_sync[SAMPLE_WIDTH];
  assign pix_rise  = pix_level & !pixel_clock_prev;

  // Memory clock strobe: every pixel edge, or two of every three.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ratio_count         <= 2'h0;
      memory_clock_strobe <= 1'b0;
    end
    else
    begin
      memory_clock_strobe <= pix_rise & (!mem_ratio | (ratio_count != RATIO_SKIP_PHASE));
      if (pix_rise)
        ratio_count <= (ratio_count == RATIO_SKIP_PHASE) ? 2'h0 : ratio_count + 2'h1;
    end
  end

  // The buffer drains on memory clock strobes, so at two-thirds rate it fills.
  sample_fifo #(
    .WIDTH (SAMPLE_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (hclk),
    .rst_n     (hresetn),
    .in_valid  (pix_rise),
    .in_ready  (fill_ready),
    .in_data   (link_sync[SAMPLE_WIDTH-1:0]),
    .out_valid (drain_valid),
    .out_ready (memory_clock_strobe),
    .out_data  (drain_data),
    .level     (fifo_level)
  );

  assign pop     = drain_valid & memory_clock_strobe;
  assign w_de    = drain_data[SAMPLE_DE];
  assign w_hs    = drain_data[SAMPLE_HS];
  assign w_vs    = drain_data[SAMPLE_VS];
  assign w_pix   = drain_data[PIXEL_WIDTH-1:0];
  assign w_green = w_pix[CHAN_W +: CHAN_W];
  assign vs_mod  = w_vs ^ in_vertical_sync_out_polarity;

  // Horizontal pulse placed by leading and trailing positions, counted in pixels.
  assign hs_edge  = w_hs & !hs_prev;
  assign next_pos = hs_edge ? 6'h00 : ((hs_pos == HPOS_IDLE) ? hs_pos : hs_pos + 6'h01);
  assign lead_pos = (lead_sel == 3'h0) ? 6'h00 : {3'h0, lead_sel} + 6'h01;
  assign gen_h    = (next_pos >= lead_pos) && (next_pos < {1'b0, trail});

  // Position counter idles saturated so no pulse appears before the first edge.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hs_prev <= 1'b0;
      hs_pos  <= HPOS_IDLE;
    end
    else if (pop)
    begin
      hs_prev <= w_hs;
      hs_pos  <= next_pos;
    end
  end

  // Panel timing and data outputs, updated once per drained pixel.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      line_pin_out        <= 1'b0;
      frame_pin_out       <= 1'b0;
      display_data_strobe <= 1'b1;
      panel_data          <= '0;
      out_de              <= 1'b0;
    end
    else if (pop)
    begin
      out_de <= w_de;
      if (bypass)
      begin
        line_pin_out        <= w_hs;
        frame_pin_out       <= w_vs;
        display_data_strobe <= w_de;
        panel_data          <= w_pix;
      end
      else
      begin
        line_pin_out        <= line_sel ? (gen_h ^ (is_tft & horizontal_sync_out_polarity)) : gen_h;
        frame_pin_out       <= frame_sel ? (vs_mod ^ (is_tft & vertical_sync_out_polarity)) : vs_mod;
        display_data_strobe <= strobe_pol ? w_de : !w_de;
        panel_data          <= mono ? {w_green, w_green, w_green} : w_pix;
      end
    end
  end

  // Shift clock follows the pixel clock; retrace gating applies to TFT only.
  assign shift_gate = bypass | (is_tft & retrace) | out_de;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      panel_shift_clock <= 1'b0;
      capture_ready     <= 1'b0;
    end
    else
    begin
      panel_shift_clock <= shift_gate & pix_level;
      capture_ready     <= fill_ready;
    end
  end

  // Register bus: writes take no wait state, reads take one so the data is fresh.
  assign addr_phase = hsel & htrans[1] & hready;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bus_state  <= BUS_IDLE;
      bus_addr   <= 12'h000;
      wr_pending <= 1'b0;
      hreadyout  <= 1'b1;
      hrdata     <= 32'h0000_0000;
      hresp      <= 1'b0;
    end
    else
    begin
      hresp      <= 1'b0;
      wr_pending <= addr_phase & hwrite;
      if (addr_phase)
        bus_addr <= haddr[11:0];
      case (bus_state)
        BUS_IDLE:
        begin
          if (addr_phase && !hwrite)
          begin
            bus_state <= BUS_READ;
            hreadyout <= 1'b0;
          end
        end
        BUS_READ:
        begin
          hrdata    <= read_word;
          hreadyout <= 1'b1;
          bus_state <= BUS_IDLE;
        end
        default:
        begin
          bus_state <= BUS_IDLE;
          hreadyout <= 1'b1;
        end
      endcase
    end
  end

  // Register storage; the reserved bit never stores.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      timing_first  <= RESET_TIMING_FIRST;
      timing_second <= RESET_TIMING_SECOND;
    end
    else if (wr_pending)
    begin
      if (bus_addr == OFFSET_TIMING_FIRST)
        timing_first <= hwdata;
      if (bus_addr == OFFSET_TIMING_SECOND)
        timing_second <= hwdata & WRITE_MASK_SECOND;
    end
  end

  // Overflow is sticky; a new overflow in the clearing cycle wins.
  assign status_clear = wr_pending && (bus_addr == OFFSET_STATUS)
                        && hwdata[STATUS_OVERFLOW_BIT];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      overflow <= 1'b0;
    else
      overflow <= (pix_rise & !fill_ready) | (overflow & !status_clear);
  end

  // Read multiplexer; unmapped addresses read as zero.
  always_comb
  begin
    read_word = 32'h0000_0000;
    case (bus_addr)
      OFFSET_TIMING_FIRST:  read_word = timing_first;
      OFFSET_TIMING_SECOND: read_word = timing_second;
      OFFSET_STATUS:
      begin
        read_word[STATUS_OVERFLOW_BIT]        = overflow;
        read_word[STATUS_LEVEL_LO +: LW]      = fifo_level;
      end
      default:              read_word = 32'h0000_0000;
    endcase
  end

  // Sequences for multi-step checks.
  sequence s_read_req;
    addr_phase && !hwrite;
  endsequence

  sequence s_read_answer;
    !hreadyout ##1 hreadyout;
  endsequence

  sequence s_hsync_start;
    pop && !bypass && !line_sel && hs_edge && (lead_sel == 3'h0) && (trail != 5'h00);
  endsequence

  a_read_wait: assert property (s_read_req |=> s_read_answer)
    else $error("read answer not given after one wait state");

  a_ratio_full: assert property (
    pix_rise && !mem_ratio |=> memory_clock_strobe)
    else $error("memory strobe missing at full ratio");

  a_ratio_skip: assert property (
    pix_rise && mem_ratio && (ratio_count == RATIO_SKIP_PHASE) |=> !memory_clock_strobe)
    else $error("memory strobe not skipped at two-thirds ratio");

  a_bypass_route: assert property (
    pop && bypass |=> (line_pin_out == $past(w_hs)) && (frame_pin_out == $past(w_vs))
                      && (panel_data == $past(w_pix)))
    else $error("bypass did not pass input through");

  a_hsync_start: assert property (s_hsync_start |=> line_pin_out)
    else $error("line pulse did not start at input edge");

  a_strobe_polarity: assert property (
    pop && !bypass |=> display_data_strobe == ($past(w_de) ~^ $past(strobe_pol)))
    else $error("data strobe polarity wrong");

  a_shift_stn_gated: assert property (
    !bypass && !is_tft && !out_de |=> !panel_shift_clock)
    else $error("shift clock ran outside active display on STN");

  a_hsync_polarity: assert property (
    pop && !bypass && line_sel |=>
      line_pin_out == ($past(gen_h) ^ ($past(is_tft) & $past(horizontal_sync_out_polarity))))
    else $error("horizontal sync polarity wrong");

  a_line_pulse_stn: assert property (
    pop && !bypass && !line_sel |=> line_pin_out == $past(gen_h))
    else $error("line pulse altered by polarity");

  a_frame_marker: assert property (
    pop && !bypass && !frame_sel |=> frame_pin_out == ($past(w_vs) ^ $past(in_vertical_sync_out_polarity)))
    else $error("first line marker wrong");

  a_vsync_polarity: assert property (
    pop && !bypass && frame_sel && is_tft |=>
      frame_pin_out == ($past(w_vs) ^ $past(in_vertical_sync_out_polarity) ^ $past(vertical_sync_out_polarity)))
    else $error("vertical sync polarity wrong");

  a_mono_mapping: assert property (
    pop && !bypass && mono |=> (panel_data[2*CHAN_W +: CHAN_W] == panel_data[CHAN_W +: CHAN_W])
                              && (panel_data[0 +: CHAN_W] == panel_data[CHAN_W +: CHAN_W]))
    else $error("mono pixel mapping wrong");

endmodule

// ===== hw/sample_fifo.sv
module sample_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32,
  localparam int AW   = $clog2(DEPTH)
)
(
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Filling side.
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  // Words held in storage.
  output logic [AW:0]           level
);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             load;

  // Storage accepts only while not full, so the source sees honest back-pressure.
  assign in_ready = (count != (AW+1)'(DEPTH));
  assign push     = in_valid & in_ready;
  assign load     = (count != '0) & (!out_valid | out_ready);
  assign level    = count;

  // Storage array has no reset; only written entries are ever read.
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

  // Pointers and occupancy.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      if (load)
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(load);
    end
  end

  // Read data come out of a register, refilled whenever the head is taken and storage holds a word.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end
    else if (load)
    begin
      out_valid <= 1'b1;
      out_data  <= mem[rd_ptr];
    end
    else if (out_ready)
      out_valid <= 1'b0;
  end

endmodule

// ===== shared/panel_timing_pkg.sv
package panel_timing_pkg;

  // Register byte offsets.
  localparam logic [11:0] OFFSET_TIMING_FIRST  = 12'h400;
  localparam logic [11:0] OFFSET_TIMING_SECOND = 12'h404;
  localparam logic [11:0] OFFSET_STATUS        = 12'h408;

  // Reset values and writable bits; bit 28 of the second register is reserved.
  localparam logic [31:0] RESET_TIMING_FIRST  = 32'h0000_0000;
  localparam logic [31:0] RESET_TIMING_SECOND = 32'h0000_0000;
  localparam logic [31:0] WRITE_MASK_SECOND   = 32'hefff_ffff;

  // Second timing register fields.
  localparam int BIT_MEM_RATIO     = 31;
  localparam int BIT_BYPASS        = 30;
  localparam int BIT_STROBE_POL    = 29;
  localparam int BIT_SHIFT_RETRACE = 27;
  localparam int BIT_LINE_SEL      = 26;
  localparam int BIT_STROBE_SEL    = 25;
  localparam int BIT_FRAME_SEL     = 24;
  localparam int BIT_VERTICAL_SYNC_OUT_POLARITY     = 23;
  localparam int BIT_HORIZONTAL_SYNC_OUT_POLARITY     = 22;
  localparam int TYPE_HI           = 21;
  localparam int TYPE_LO           = 20;
  localparam int BIT_MONO          = 19;
  localparam int FORMAT_HI         = 18;
  localparam int FORMAT_LO         = 16;

  // First timing register fields.
  localparam int BIT_IN_VERTICAL_SYNC_OUT_POLARITY = 30;
  localparam int LEAD_HI          = 7;
  localparam int LEAD_LO          = 5;
  localparam int TRAIL_HI         = 4;
  localparam int TRAIL_LO         = 0;

  // Status register fields.
  localparam int STATUS_OVERFLOW_BIT = 0;
  localparam int STATUS_LEVEL_LO     = 8;

  // Panel type codes.
  localparam logic [1:0] PANEL_STN = 2'h0;
  localparam logic [1:0] PANEL_TFT = 2'h1;

  // Pixel and sample word layout.
  localparam int PIXEL_WIDTH  = 18;
  localparam int CHAN_W       = 6;
  localparam int SAMPLE_WIDTH = PIXEL_WIDTH + 3;
  localparam int SAMPLE_DE    = 20;
  localparam int SAMPLE_HS    = 19;
  localparam int SAMPLE_VS    = 18;

  // Buffer depth and the skipped phase of the two-thirds memory clock.
  localparam int         FIFO_DEPTH_DEFAULT = 32;
  localparam logic [1:0] RATIO_SKIP_PHASE   = 2'h2;
  localparam logic [5:0] HPOS_IDLE          = 6'h3f;

  // Register bus slave states.
  typedef enum logic [1:0]
  {
    BUS_IDLE = 2'b01,
    BUS_READ = 2'b10
  } bus_state_t;

endpackage
